// [logic/line_event_pkg.sv]
// Constants, register map and carrier types for the external line event controller
//
// Summary of operation
// - Written one on trigger bit fires line
// - Lines 0-15 take pins via four selectors
// - Lines 0-9 choose port A or B
// - Line 16 follows supply voltage detector
// - Lines 19 and 20 follow comparators
// - Line 24 follows independent watchdog interrupt
// - All ten registers reset to zero
// - Interrupt mask bit gates line interrupt
// - Event mask bit gates line event
// - Rising select bit enables rising edge trigger
// - Falling select bit enables falling edge trigger
// - Detected trigger sets sticky pending flag
// - Pending cleared by one, deselect, polarity change
// - Software trigger sets pending flag
`default_nettype none

package line_event_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Line counts and fixed source positions
  localparam int LINE_COUNT      = 25;  // Lines served
  localparam int GPIO_LINES      = 16;  // Lines fed from pins
  localparam int DUAL_PORT_LINES = 10;  // Lines that may pick port B
  localparam int SEL_REG_COUNT   = 4;   // Port selector registers
  localparam int SEL_PER_REG     = 4;   // Lines per selector register
  localparam int SEL_FIELD_WIDTH = 4;   // Bits per selector field
  localparam int LINE_SUPPLY     = 16;  // Supply voltage detector line
  localparam int LINE_CMP1       = 19;  // First comparator line
  localparam int LINE_CMP2       = 20;  // Second comparator line
  localparam int LINE_WATCHDOG   = 24;  // Independent watchdog line
  localparam int SPARE_COUNT     = 5;   // Lines 17, 18, 21, 22, 23

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the APB
  localparam int ADDR_WIDTH = 8;
  localparam logic [7:0] OFS_INT_MASK  = 8'h00;
  localparam logic [7:0] OFS_EVT_MASK  = 8'h04;
  localparam logic [7:0] OFS_RISE_SEL  = 8'h08;
  localparam logic [7:0] OFS_FALL_SEL  = 8'h0C;
  localparam logic [7:0] OFS_SW_TRIG   = 8'h10;
  localparam logic [7:0] OFS_PENDING   = 8'h14;
  localparam logic [7:0] OFS_PORT_SEL0 = 8'h18;
  localparam logic [7:0] OFS_PORT_SEL3 = 8'h24;

  // Reset value shared by every register
  localparam logic [31:0] REG_RESET  = 32'h0000_0000;
  localparam logic [24:0] LINE_RESET = 25'h000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger sources grouped as one carrier
  typedef struct packed {
    logic [15:0] port_a;    // Port A pins 15..0
    logic [9:0]  port_b;    // Port B pins 9..0
    logic        supply;    // Supply voltage detector output
    logic        cmp1;      // First comparator output
    logic        cmp2;      // Second comparator output
    logic        watchdog;  // Independent watchdog interrupt
    logic [4:0]  spare;     // Other internal sources, lines 23,22,21,18,17
  } line_sources_t;

endpackage

`default_nettype wire

// [logic/line_edge_detect.sv]
// Per-line rising and falling edge detector for synchronous levels
`timescale 1ns/1ps
`default_nettype none

module line_edge_detect
  import line_event_pkg::*;
#(
  parameter int WIDTH = LINE_COUNT  // Lines watched
)
(
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] level_i,
  output logic      [WIDTH-1:0] rise_o,
  output logic      [WIDTH-1:0] fall_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check
  if (WIDTH < 1)
  begin : g_width_check
    $error("line_edge_detect needs at least one line");
  end

  logic [WIDTH-1:0] prev_reg;   // Level seen one cycle earlier
  logic [WIDTH-1:0] prev_next;  // Next value of prev_reg

  ////////////////////////////////////////////////////////////////////////////
  // Next value: follow the input
  always_comb
  begin
    prev_next = level_i;
  end

  // Register only
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      prev_reg <= '0;
    end
    else
    begin
      prev_reg <= prev_next;
    end
  end

  // Edges compare present against previous level
  assign rise_o = level_i & ~prev_reg;
  assign fall_o = ~level_i & prev_reg;

endmodule

`default_nettype wire

// [logic/external_line_event_controller.sv]
// Top of the external line event controller with its APB register slave
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module external_line_event_controller
  import line_event_pkg::*;
#(
  parameter int LINES = LINE_COUNT  // Lines served; logic is built for 25
)
(
  input  wire logic                  clock_i,
  input  wire logic                  reset_n_i,
  // APB slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [ADDR_WIDTH-1:0] paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  // Trigger sources
  input  wire line_sources_t         line_sources_i,
  // Requests to the processor and the wake logic
  output logic      [LINES-1:0]      line_irq_o,
  output logic      [LINES-1:0]      event_o,
  output logic                       irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration check
  if (LINES != LINE_COUNT)
  begin : g_lines_check
    $error("external_line_event_controller serves exactly 25 lines");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // True when the byte address selects a register
  function automatic logic is_mapped(input logic [ADDR_WIDTH-1:0] addr);
    logic hit;
    hit = (addr[1:0] == 2'b00) && (addr <= OFS_PORT_SEL3);
    return hit;
  endfunction

  // Bits that differ between the old and the written value
  function automatic logic [LINES-1:0] changed_bits(
    input logic [LINES-1:0] old_value,
    input logic [LINES-1:0] new_value
  );
    logic [LINES-1:0] diff;
    diff = old_value ^ new_value;
    return diff;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [LINES-1:0]      int_mask_reg;      // line_interrupt_mask
  logic [LINES-1:0]      int_mask_next;
  logic [LINES-1:0]      evt_mask_reg;      // line_event_mask
  logic [LINES-1:0]      evt_mask_next;
  logic [LINES-1:0]      rise_sel_reg;      // rising_edge_select
  logic [LINES-1:0]      rise_sel_next;
  logic [LINES-1:0]      fall_sel_reg;      // falling_edge_select
  logic [LINES-1:0]      fall_sel_next;
  logic [LINES-1:0]      sw_trig_reg;       // software_line_trigger
  logic [LINES-1:0]      sw_trig_next;
  logic [LINES-1:0]      pending_reg;       // line_pending_flags
  logic [LINES-1:0]      pending_next;
  logic [GPIO_LINES-1:0] port_b_sel_reg;    // One per line: 1 picks port B
  logic [GPIO_LINES-1:0] port_b_sel_next;
  logic [LINES-1:0]      event_reg;         // One-cycle event pulses
  logic [LINES-1:0]      event_next;
  logic [31:0]           prdata_reg;        // Read data for access phase
  logic [31:0]           prdata_next;

  // Bus decode
  logic                  wr_access;         // Write taken this edge
  logic                  rd_setup;          // Read setup cycle
  logic [LINES-1:0]      wdata_lines;       // Write data, line bits only
  logic                  wr_int_mask;
  logic                  wr_evt_mask;
  logic                  wr_rise_sel;
  logic                  wr_fall_sel;
  logic                  wr_sw_trig;
  logic                  wr_pending;

  // Line datapath
  logic [LINES-1:0]      line_level;        // Selected source per line
  logic [LINES-1:0]      line_rise;         // Rising edges seen
  logic [LINES-1:0]      line_fall;         // Falling edges seen
  logic [LINES-1:0]      edge_trig;         // Hardware triggers
  logic [LINES-1:0]      soft_trig;         // Software triggers
  logic [LINES-1:0]      pend_clear;        // Pending clear requests
  logic [LINES-1:0]      pend_set;          // Pending set requests

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; writes happen only in the access phase
  always_comb
  begin
    wr_access   = psel_i && penable_i && pwrite_i && is_mapped(paddr_i);
    rd_setup    = psel_i && !penable_i && !pwrite_i;
    // Reserved upper bits are dropped on write
    wdata_lines = pwdata_i[LINES-1:0];
    wr_int_mask = wr_access && (paddr_i == OFS_INT_MASK);
    wr_evt_mask = wr_access && (paddr_i == OFS_EVT_MASK);
    wr_rise_sel = wr_access && (paddr_i == OFS_RISE_SEL);
    wr_fall_sel = wr_access && (paddr_i == OFS_FALL_SEL);
    wr_sw_trig  = wr_access && (paddr_i == OFS_SW_TRIG);
    wr_pending  = wr_access && (paddr_i == OFS_PENDING);
  end

  // Zero-wait slave; unmapped or misaligned address answers with an error
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !is_mapped(paddr_i);
  assign prdata_o  = prdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Source selection per line
  always_comb
  begin
    line_level = '0;
    for (int i = 0; i < GPIO_LINES; i++)
    begin
      line_level[i] = line_sources_i.port_a[i];
    end
    for (int i = 0; i < DUAL_PORT_LINES; i++)
    begin
      if (port_b_sel_reg[i])
      begin
        line_level[i] = line_sources_i.port_b[i];
      end
    end
    line_level[LINE_SUPPLY]   = line_sources_i.supply;
    line_level[LINE_CMP1]     = line_sources_i.cmp1;
    line_level[LINE_CMP2]     = line_sources_i.cmp2;
    line_level[LINE_WATCHDOG] = line_sources_i.watchdog;
    // Remaining internal sources
    line_level[17]            = line_sources_i.spare[0];
    line_level[18]            = line_sources_i.spare[1];
    line_level[21]            = line_sources_i.spare[2];
    line_level[22]            = line_sources_i.spare[3];
    line_level[23]            = line_sources_i.spare[4];
  end

  // Edge detection on the selected levels
  line_edge_detect #(
    .WIDTH     (LINES)
  ) u_edge (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .level_i   (line_level),
    .rise_o    (line_rise),
    .fall_o    (line_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Trigger and pending logic
  always_comb
  begin
    edge_trig = line_rise & rise_sel_reg;
    edge_trig = edge_trig | (line_fall & fall_sel_reg);
    soft_trig = wr_sw_trig ? wdata_lines : '0;
    pend_clear = wr_pending ? wdata_lines : '0;
    // Clear on deselect or polarity change
    if (wr_rise_sel)
    begin
      pend_clear = pend_clear | changed_bits(rise_sel_reg, wdata_lines);
    end
    if (wr_fall_sel)
    begin
      pend_clear = pend_clear | changed_bits(fall_sel_reg, wdata_lines);
    end
    pend_set = edge_trig;
    pend_set = pend_set | soft_trig;
    // Set wins over a clear in the same cycle
    pending_next = (pending_reg & ~pend_clear) | pend_set;
    event_next = (edge_trig | soft_trig) & evt_mask_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register next values
  always_comb
  begin
    int_mask_next   = wr_int_mask ? wdata_lines : int_mask_reg;
    evt_mask_next   = wr_evt_mask ? wdata_lines : evt_mask_reg;
    rise_sel_next   = wr_rise_sel ? wdata_lines : rise_sel_reg;
    fall_sel_next   = wr_fall_sel ? wdata_lines : fall_sel_reg;
    // Trigger bits stay set until the pending flag is cleared
    sw_trig_next    = (sw_trig_reg & ~pend_clear) | soft_trig;
    port_b_sel_next = port_b_sel_reg;
    // Selector fields: bit 0 of each nibble picks port B
    for (int k = 0; k < SEL_REG_COUNT; k++)
    begin
      if (wr_access && (paddr_i == OFS_PORT_SEL0 + 8'(4 * k)))
      begin
        for (int j = 0; j < SEL_PER_REG; j++)
        begin
          if ((SEL_PER_REG * k + j) < DUAL_PORT_LINES)
          begin
            port_b_sel_next[SEL_PER_REG * k + j] = pwdata_i[SEL_FIELD_WIDTH * j];
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup cycle
  always_comb
  begin
    prdata_next = prdata_reg;
    if (rd_setup)
    begin
      prdata_next = REG_RESET;
      unique case (paddr_i)
        OFS_INT_MASK:
        begin
          prdata_next[LINES-1:0] = int_mask_reg;
        end
        OFS_EVT_MASK:
        begin
          prdata_next[LINES-1:0] = evt_mask_reg;
        end
        OFS_RISE_SEL:
        begin
          prdata_next[LINES-1:0] = rise_sel_reg;
        end
        OFS_FALL_SEL:
        begin
          prdata_next[LINES-1:0] = fall_sel_reg;
        end
        OFS_SW_TRIG:
        begin
          prdata_next[LINES-1:0] = sw_trig_reg;
        end
        OFS_PENDING:
        begin
          prdata_next[LINES-1:0] = pending_reg;
        end
        default:
        begin
          // Selector registers; unmapped addresses read zero
          for (int k = 0; k < SEL_REG_COUNT; k++)
          begin
            if (paddr_i == OFS_PORT_SEL0 + 8'(4 * k))
            begin
              for (int j = 0; j < SEL_PER_REG; j++)
              begin
                prdata_next[SEL_FIELD_WIDTH * j] = port_b_sel_reg[SEL_PER_REG * k + j];
              end
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      int_mask_reg   <= LINE_RESET;
      evt_mask_reg   <= LINE_RESET;
      rise_sel_reg   <= LINE_RESET;
      fall_sel_reg   <= LINE_RESET;
      sw_trig_reg    <= LINE_RESET;
      pending_reg    <= LINE_RESET;
      port_b_sel_reg <= '0;
      event_reg      <= '0;
      prdata_reg     <= REG_RESET;
    end
    else
    begin
      int_mask_reg   <= int_mask_next;
      evt_mask_reg   <= evt_mask_next;
      rise_sel_reg   <= rise_sel_next;
      fall_sel_reg   <= fall_sel_next;
      sw_trig_reg    <= sw_trig_next;
      pending_reg    <= pending_next;
      port_b_sel_reg <= port_b_sel_next;
      event_reg      <= event_next;
      prdata_reg     <= prdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  // Interrupt gated by mask
  assign line_irq_o = pending_reg & int_mask_reg;
  // Single level request while any unmasked flag is set
  assign irq_o      = |line_irq_o;
  assign event_o    = event_reg;

endmodule

`default_nettype wire

// [tb/line_event_sva.sv]
// Port-level checker for the line event controller
`timescale 1ns/1ps
`default_nettype none
module line_event_sva
  import line_event_pkg::*;
#(
  parameter int LINES = LINE_COUNT  // Lines served
)
(
  input wire logic                  clock_i,
  input wire logic                  reset_n_i,
  input wire logic                  psel_i,
  input wire logic                  penable_i,
  input wire logic                  pwrite_i,
  input wire logic [ADDR_WIDTH-1:0] paddr_i,
  input wire logic [31:0]           pwdata_i,
  input wire logic [31:0]           prdata_o,
  input wire logic                  pready_o,
  input wire logic                  pslverr_o,
  input wire line_sources_t         line_sources_i,
  input wire logic [LINES-1:0]      line_irq_o,
  input wire logic [LINES-1:0]      event_o,
  input wire logic                  irq_o
);
  logic [LINES-1:0] imr_copy;  // Interrupt mask as written
  logic [LINES-1:0] emr_copy;  // Event mask as written
  logic             wr_hit;    // Write completes at this edge
  logic             bad_addr;  // Address outside the map
  assign wr_hit = psel_i && penable_i && pwrite_i && pready_o;
  assign bad_addr = (paddr_i > OFS_PORT_SEL3) || (paddr_i[1:0] != 2'h0);
  ////////////////////////////////////////////////////////////////////////////
  // Shadow copies of both mask registers
  always_ff @(posedge clock_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      imr_copy <= '0;
      emr_copy <= '0;
    end
    else if (wr_hit && paddr_i == OFS_INT_MASK)
      imr_copy <= pwdata_i[LINES-1:0];
    else if (wr_hit && paddr_i == OFS_EVT_MASK)
      emr_copy <= pwdata_i[LINES-1:0];
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////////////////
  // masked lines silent, summary, pulses, sticky flags, triggers, clears, bus replies
  a_irq_masked: assert property ((line_irq_o & ~imr_copy) == '0)
    else $error("interrupt on masked line");
  a_event_masked: assert property ((event_o & ~$past(emr_copy)) == '0)
    else $error("event on masked line");
  a_irq_summary: assert property (irq_o == (|line_irq_o))
    else $error("summary interrupt differs");
  a_event_pulse: assert property (|event_o |=> (event_o & $past(event_o)) == '0)
    else $error("event wider than one cycle");
  a_irq_sticky: assert property (irq_o && !(psel_i && penable_i && pwrite_i) |=> irq_o)
    else $error("interrupt dropped without write");
  a_sw_sets: assert property (wr_hit && paddr_i == OFS_SW_TRIG |=>
    ((line_irq_o & imr_copy & $past(pwdata_i[LINES-1:0])) ==
     (imr_copy & $past(pwdata_i[LINES-1:0]))))
    else $error("software trigger not pending");
  a_w1c_clear: assert property (wr_hit && paddr_i == OFS_PENDING |=>
    (line_irq_o & $past(pwdata_i[LINES-1:0])) == '0)
    else $error("pending not cleared");
  a_bad_addr: assert property (psel_i && penable_i && bad_addr |->
    pslverr_o && (pwrite_i || prdata_o == 32'h0000_0000))
    else $error("unmapped access not refused");
  a_good_addr: assert property (psel_i && penable_i && !bad_addr |->
    !pslverr_o && (pwrite_i || prdata_o[31:25] == 7'h00))
    else $error("mapped access refused");
  a_ready_high: assert property (pready_o)
    else $error("ready low");
endmodule
bind external_line_event_controller line_event_sva #(.LINES(LINES)) u_sva (
  .clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .line_sources_i(line_sources_i),
  .line_irq_o(line_irq_o), .event_o(event_o), .irq_o(irq_o));
`default_nettype wire

// [tb/wake_sink.sv]
// Behavioural wake logic that counts event requests
`timescale 1ns/1ps
`default_nettype none
module wake_sink
  import line_event_pkg::*;
(
  input  wire logic                  clock_i,
  input  wire logic                  reset_n_i,
  input  wire logic [LINE_COUNT-1:0] event_i,
  output logic      [15:0]           event_total_o
);
  logic [15:0] total_next;  // Count after this cycle's pulses
  // Add every event bit seen this cycle
  always_comb
    total_next = event_total_o + 16'($countones(event_i));
  always_ff @(posedge clock_i or negedge reset_n_i)
    if (!reset_n_i)
      event_total_o <= 16'h0000;
    else
      event_total_o <= total_next;
endmodule
`default_nettype wire

// [tb/tb.sv]
// Self-checking testbench for the line event controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  import line_event_pkg::*;
  typedef struct {
    logic [24:0] rise;   // Rising select
    logic [24:0] fall;   // Falling select
    logic [31:0] sel2;   // Selector for lines 8 to 11
    int          which;  // Source kind
    int          idx;    // Pin index
    bit          up;     // Source rises
    logic [24:0] exp;    // Pending expected
  } row_t;
  logic          clock_i;
  logic          reset_n;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [7:0]    paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  line_sources_t srcs;
  logic [24:0]   line_irq;
  logic [24:0]   events;
  logic          irq;
  logic [15:0]   ev_total;
  logic [15:0]   n0;
  logic [31:0]   q;
  logic          e;
  int            fail_count;
  int            comparisons;
  row_t          r;
  row_t rows [10] = '{
    '{25'h200, 0, 32'h10, 1, 9, 1, 25'h200},
    '{25'h200, 0, 32'h0, 0, 9, 1, 25'h200},
    '{25'h200, 0, 32'h10, 0, 9, 1, 25'h0},
    '{25'h400, 0, 32'h100, 0, 10, 1, 25'h400},
    '{25'h1, 0, 32'h0, 0, 0, 1, 25'h1},
    '{0, 25'h1_0000, 32'h0, 2, 0, 0, 25'h1_0000},
    '{25'h1_0000, 0, 32'h0, 2, 0, 0, 25'h0},
    '{25'h8_0000, 0, 32'h0, 3, 0, 1, 25'h8_0000},
    '{0, 25'h10_0000, 32'h0, 4, 0, 0, 25'h10_0000},
    '{25'h100_0000, 0, 32'h0, 5, 0, 1, 25'h100_0000}};
  external_line_event_controller DUT (
    .clock_i(clock_i), .reset_n_i(reset_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .line_sources_i(srcs),
    .line_irq_o(line_irq), .event_o(events), .irq_o(irq));
  wake_sink sink (.clock_i(clock_i), .reset_n_i(reset_n), .event_i(events),
    .event_total_o(ev_total));
  initial
  begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Closing report and verdict
  task automatic summarize();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    comparisons++;
    if (seen !== want)
    begin
      fail_count++;
      $display("wrong value at %0t: %s %h not %h", $time, what, seen, want);
    end
  endtask
  // One APB transfer, held until ready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fail_count++;
      summarize();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic line_sources_t mk(input int which, input int idx);
    line_sources_t s;
    s = '0;
    case (which)
      0: s.port_a[idx] = 1'b1;
      1: s.port_b[idx] = 1'b1;
      2: s.supply = 1'b1;
      3: s.cmp1 = 1'b1;
      4: s.cmp2 = 1'b1;
      default: s.watchdog = 1'b1;
    endcase
    return s;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    srcs = '0;
    reset_n = 1'b0;
    fail_count = 0;
    comparisons = 0;
    repeat (2) @(posedge clock_i);
    reset_n <= 1'b1;
    apb(1'b1, OFS_INT_MASK, 32'h01FF_FFFF);
    apb(1'b0, OFS_INT_MASK, 32'h0);
    check(q, 32'h01FF_FFFF, "mask readback");
    apb(1'b1, OFS_EVT_MASK, 32'h01FF_FFFF);
    foreach (rows[i])
    begin
      r = rows[i];
      srcs <= r.up ? '0 : mk(r.which, r.idx);
      apb(1'b1, OFS_RISE_SEL, {7'h00, r.rise});
      apb(1'b1, OFS_FALL_SEL, {7'h00, r.fall});
      apb(1'b1, OFS_PORT_SEL0 + 8'h08, r.sel2);
      apb(1'b1, OFS_PENDING, 32'h01FF_FFFF);
      n0 = ev_total;
      srcs <= r.up ? mk(r.which, r.idx) : '0;
      repeat (3) @(posedge clock_i);
      apb(1'b0, OFS_PENDING, 32'h0);
      check(q, {7'h00, r.exp}, "pending");
      check({16'h0, ev_total - n0}, (r.exp != 0) ? 32'h1 : 32'h0, "events");
    end
    apb(1'b1, OFS_RISE_SEL, 32'h0);
    apb(1'b0, OFS_PENDING, 32'h0);
    check(q, 32'h0, "deselect clear");
    apb(1'b1, OFS_SW_TRIG, 32'h0100_0000);
    apb(1'b1, OFS_FALL_SEL, 32'h0100_0000);
    apb(1'b0, OFS_PENDING, 32'h0);
    check(q, 32'h0, "polarity clear");
    apb(1'b1, OFS_INT_MASK, 32'h0000_0008);
    apb(1'b1, OFS_EVT_MASK, 32'h0000_0008);
    n0 = ev_total;
    apb(1'b1, OFS_SW_TRIG, 32'h0000_0028);
    repeat (2) @(posedge clock_i);
    check({7'h00, line_irq}, 32'h8, "line irq");
    check({16'h0, ev_total - n0}, 32'h1, "sw events");
    apb(1'b0, OFS_PENDING, 32'h0);
    check(q, 32'h28, "sw pending");
    apb(1'b0, OFS_SW_TRIG, 32'h0);
    check(q, 32'h28, "sw trigger bits");
    apb(1'b1, OFS_PENDING, 32'h0000_0008);
    apb(1'b0, OFS_PENDING, 32'h0);
    check({31'h0, irq}, 32'h0, "irq after clear");
    check(q, 32'h20, "masked stays");
    apb(1'b0, 8'h28, 32'h0);
    check({e, q[30:0]}, 32'h8000_0000, "unmapped");
    apb(1'b0, 8'h02, 32'h0);
    check({31'h0, e}, 32'h1, "misaligned");
    apb(1'b1, OFS_PORT_SEL0, 32'h0000_0001);
    apb(1'b0, OFS_PORT_SEL0, 32'h0);
    check(q, 32'h1, "selector readback");
    reset_n <= 1'b0;
    repeat (2) @(posedge clock_i);
    reset_n <= 1'b1;
    for (int k = 0; k < 6; k++)
    begin
      apb(1'b0, 8'(4 * k), 32'h0);
      check(q, REG_RESET, "reset value");
    end
    summarize();
  end
endmodule
`default_nettype wire
